// file: verilog/lowrate_phy_frame_path.sv
// Purpose: Packet framer and deframer between a host serial port and a modem
// Assumes: Modem takes transmit bytes with valid/ready, gives receive bytes with valid only; energy_i is a live level
// Notes: Host commands are 16-bit words: opcode in the top nibble
// Function
// RQ1 - Host talks only over serial port and irq
// RQ2 - Packet mode buffers; stream mode moves single words
// RQ3 - Payload limited to 125 bytes
// RQ4 - Transmit preamble, delimiter, length before payload
// RQ5 - Append frame check after payload
// RQ6 - Parse header, store payload and check in RAM
// RQ7 - Receive check compared, pass or fail result
// RQ8 - Link quality over 64 us after preamble
// RQ9 - Packet mode: one interrupt per received packet
// RQ10 - Stream mode: interrupt per received word
// RQ11 - Channel assessment from integrated energy
// RQ12 - Sixteen channels, four-bit selector
// RQ13 - Host loads buffer, requests send, gets interrupt
// RQ14 - Check uses x16+x12+x5+1 polynomial

`timescale 1ns/10ps

module lowrate_phy_frame_path #(
  parameter int MAX_PAYLOAD = frame_pkg::MAX_PAYLOAD,
  parameter logic [7:0] CCA_LEVEL = frame_pkg::CCA_LEVEL
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host serial port and interrupt
  input wire logic spi_sclk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic irq_o,
  // Modem transmit side
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Modem receive side
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] energy_i,
  output logic [3:0] channel_o
);

  localparam int RX_DEPTH = MAX_PAYLOAD + frame_pkg::FCS_N;
  localparam int AW = frame_pkg::IDX_W;

  // ---------------------------------------------------------------------
  // Host command decode
  // ---------------------------------------------------------------------
  logic [15:0] cmd;
  logic cmd_done;
  logic [15:0] reply;
  logic stream;
  logic [frame_pkg::FLAG_N-1:0] flags;
  logic crc_ok;
  logic cca_busy;
  logic [7:0] lqi;
  logic [7:0] rx_last;
  logic [7:0] rx_ram [RX_DEPTH];

  spi_word_port u_port (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sclk_i(spi_sclk_i),
    .csn_i(spi_csn_i),
    .mosi_i(spi_mosi_i),
    .miso_o(spi_miso_o),
    .reply_i(reply),
    .word_o(cmd),
    .done_o(cmd_done)
  );

  // Opcode strobes, one cycle each
  wire [3:0] op = cmd[frame_pkg::OP_MSB:frame_pkg::OP_LSB];
  wire [AW-1:0] arg_idx = cmd[AW-1:0];
  wire cmd_cfg = cmd_done && op == frame_pkg::OP_CFG;
  wire cmd_tx_wr = cmd_done && op == frame_pkg::OP_TX_WR;
  wire cmd_tx_len = cmd_done && op == frame_pkg::OP_TX_LEN;
  wire cmd_tx_go = cmd_done && op == frame_pkg::OP_TX_GO;
  wire cmd_rx_go = cmd_done && op == frame_pkg::OP_RX_GO;
  wire cmd_rx_rd = cmd_done && op == frame_pkg::OP_RX_RD;
  wire cmd_stat = cmd_done && op == frame_pkg::OP_STAT;
  wire cmd_cca = cmd_done && op == frame_pkg::OP_CCA;

  // Reply built from state before this word's own effects
  wire rd_ok = arg_idx < AW'(RX_DEPTH);
  wire [7:0] rd_byte = cmd[frame_pkg::RD_LAST_BIT] ? rx_last :
                       (rd_ok ? rx_ram[arg_idx] : 8'h00);
  assign reply = (op == frame_pkg::OP_STAT) ? {1'b0, flags, cca_busy, crc_ok, lqi} :
                 (op == frame_pkg::OP_RX_RD) ? {8'h00, rd_byte} : 16'h0000; // RQ1

  // Mode and channel; channel changes take effect at once
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stream <= 1'b0;
      channel_o <= 4'h0;
    end else if (cmd_cfg) begin
      stream <= cmd[frame_pkg::CFG_MODE_BIT]; // RQ2
      channel_o <= cmd[frame_pkg::CHAN_W-1:0]; // RQ12
    end
  end

  // ---------------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------------
  frame_pkg::tx_state_t tx_st;
  logic [AW-1:0] tx_len;
  logic [AW-1:0] tx_wptr;
  logic [AW-1:0] tx_cnt;
  logic [7:0] tx_ram [MAX_PAYLOAD];
  logic [7:0] strm_byte;
  logic strm_full;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_next;

  wire tx_idle = tx_st == frame_pkg::TX_IDLE;
  wire out_free = !tx_valid_o || tx_ready_i;
  wire pay_avail = stream ? strm_full : 1'b1;
  wire [7:0] pay_byte = stream ? strm_byte : tx_ram[tx_cnt];
  wire pay_take = tx_st == frame_pkg::TX_PAY && out_free && pay_avail;
  wire pay_last = tx_cnt == tx_len - 7'h01;
  wire [7:0] len_byte = 8'(tx_len) + 8'(frame_pkg::FCS_N);
  wire tx_fin = tx_st == frame_pkg::TX_DONE && out_free;
  wire len_big = arg_idx > AW'(MAX_PAYLOAD);

  crc16_step u_tx_crc (
    .crc_i(tx_crc),
    .data_i(pay_byte),
    .crc_o(tx_crc_next)
  );

  // Host side of the payload store; longer payloads are clamped
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_len <= '0;
      tx_wptr <= '0;
    end else if (cmd_tx_len && tx_idle) begin
      tx_len <= len_big ? AW'(MAX_PAYLOAD) : arg_idx; // RQ3
      tx_wptr <= '0;
    end else if (cmd_tx_wr && !stream && tx_wptr < AW'(MAX_PAYLOAD)) begin
      tx_ram[tx_wptr] <= cmd[7:0]; // RQ13
      tx_wptr <= tx_wptr + 7'h01;
    end
  end

  // Single stream holding byte; a write while full is dropped
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      strm_full <= 1'b0;
      strm_byte <= 8'h00;
    end else if (cmd_tx_wr && stream && !strm_full) begin
      strm_full <= 1'b1;
      strm_byte <= cmd[7:0];
    end else if (pay_take && stream) begin
      strm_full <= 1'b0; // RQ2
    end
  end

  // Frame builder; output byte holds until the modem takes it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_st <= frame_pkg::TX_IDLE;
      tx_cnt <= '0;
      tx_crc <= frame_pkg::CRC_INIT;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
    end else begin
      if (out_free) begin
        tx_valid_o <= 1'b0;
      end
      case (tx_st)
        frame_pkg::TX_IDLE: begin
          if (cmd_tx_go) begin
            tx_st <= frame_pkg::TX_PRE; // RQ13
            tx_cnt <= '0;
            tx_crc <= frame_pkg::CRC_INIT;
          end
        end
        frame_pkg::TX_PRE: begin
          if (out_free) begin
            tx_byte_o <= frame_pkg::PRE_BYTE; // RQ4
            tx_valid_o <= 1'b1;
            tx_cnt <= tx_cnt + 7'h01;
            if (tx_cnt == AW'(frame_pkg::PRE_N - 1)) begin
              tx_st <= frame_pkg::TX_SFD;
            end
          end
        end
        frame_pkg::TX_SFD: begin
          if (out_free) begin
            tx_byte_o <= frame_pkg::SFD_BYTE; // RQ4
            tx_valid_o <= 1'b1;
            tx_st <= frame_pkg::TX_LEN;
          end
        end
        frame_pkg::TX_LEN: begin
          if (out_free) begin
            tx_byte_o <= len_byte; // RQ4
            tx_valid_o <= 1'b1;
            tx_cnt <= '0;
            tx_st <= (tx_len == '0) ? frame_pkg::TX_FCS : frame_pkg::TX_PAY;
          end
        end
        frame_pkg::TX_PAY: begin
          if (pay_take) begin
            tx_byte_o <= pay_byte;
            tx_valid_o <= 1'b1;
            tx_crc <= tx_crc_next; // RQ14
            tx_cnt <= pay_last ? '0 : tx_cnt + 7'h01;
            if (pay_last) begin
              tx_st <= frame_pkg::TX_FCS;
            end
          end
        end
        frame_pkg::TX_FCS: begin
          if (out_free) begin
            tx_byte_o <= (tx_cnt == '0) ? tx_crc[7:0] : tx_crc[15:8]; // RQ5
            tx_valid_o <= 1'b1;
            tx_cnt <= tx_cnt + 7'h01;
            if (tx_cnt == AW'(frame_pkg::FCS_N - 1)) begin
              tx_st <= frame_pkg::TX_DONE;
            end
          end
        end
        frame_pkg::TX_DONE: begin
          if (out_free) begin
            tx_st <= frame_pkg::TX_IDLE;
          end
        end
        default: tx_st <= frame_pkg::TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------------
  frame_pkg::rx_state_t rx_st;
  logic [AW-1:0] rx_idx;
  logic [AW-1:0] rx_len;
  logic [15:0] rx_crc;
  logic [15:0] rx_crc_next;

  wire rx_in_pay = rx_st == frame_pkg::RX_PAY && rx_valid_i;
  wire rx_is_pre = rx_byte_i == frame_pkg::PRE_BYTE;
  wire pre_end = rx_st == frame_pkg::RX_HUNT && rx_valid_i && rx_is_pre &&
                 rx_idx == AW'(frame_pkg::PRE_N - 1);
  wire len_ok = rx_byte_i >= 8'(frame_pkg::FCS_N) && rx_byte_i <= 8'(RX_DEPTH);
  wire rx_fin = rx_in_pay && rx_idx == rx_len - 7'h01;

  crc16_step u_rx_crc (
    .crc_i(rx_crc),
    .data_i(rx_byte_i),
    .crc_o(rx_crc_next)
  );

  // Deframer; one packet per arm, bad length drops back to hunting
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_st <= frame_pkg::RX_OFF;
      rx_idx <= '0;
      rx_len <= '0;
      rx_crc <= frame_pkg::CRC_INIT;
      rx_last <= 8'h00;
      crc_ok <= 1'b0;
    end else begin
      case (rx_st)
        frame_pkg::RX_OFF: begin
          if (cmd_rx_go) begin
            rx_st <= frame_pkg::RX_HUNT;
            rx_idx <= '0;
          end
        end
        frame_pkg::RX_HUNT: begin
          if (rx_valid_i) begin
            rx_idx <= rx_is_pre ? rx_idx + 7'h01 : '0;
            if (pre_end) begin
              rx_st <= frame_pkg::RX_SFD; // RQ6
            end
          end
        end
        frame_pkg::RX_SFD: begin
          if (rx_valid_i && rx_byte_i == frame_pkg::SFD_BYTE) begin
            rx_st <= frame_pkg::RX_LEN; // RQ6
          end else if (rx_valid_i && !rx_is_pre) begin
            rx_st <= frame_pkg::RX_HUNT;
            rx_idx <= '0;
          end
        end
        frame_pkg::RX_LEN: begin
          if (rx_valid_i) begin
            rx_st <= len_ok ? frame_pkg::RX_PAY : frame_pkg::RX_HUNT; // RQ3
            rx_len <= rx_byte_i[AW-1:0];
            rx_idx <= '0;
            rx_crc <= frame_pkg::CRC_INIT;
          end
        end
        frame_pkg::RX_PAY: begin
          if (rx_valid_i) begin
            rx_ram[rx_idx] <= rx_byte_i; // RQ6
            rx_last <= rx_byte_i;
            rx_crc <= rx_crc_next; // RQ14
            rx_idx <= rx_idx + 7'h01;
            if (rx_fin) begin
              crc_ok <= rx_crc_next == 16'h0000; // RQ7
              rx_st <= frame_pkg::RX_OFF;
            end
          end
        end
        default: rx_st <= frame_pkg::RX_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Energy windows: link quality and channel assessment
  // ---------------------------------------------------------------------
  logic lqi_run;
  logic cca_run;
  logic [frame_pkg::WIN_W-1:0] lqi_cnt;
  logic [frame_pkg::WIN_W-1:0] cca_cnt;
  logic [frame_pkg::LQI_ACC_W-1:0] lqi_acc;
  logic [frame_pkg::CCA_ACC_W-1:0] cca_acc;

  // Sums are wide enough for a full window at peak energy
  wire [frame_pkg::LQI_ACC_W-1:0] lqi_sum = lqi_acc + frame_pkg::LQI_ACC_W'(energy_i);
  wire [frame_pkg::CCA_ACC_W-1:0] cca_sum = cca_acc + frame_pkg::CCA_ACC_W'(energy_i);
  wire lqi_end = lqi_run && lqi_cnt == frame_pkg::WIN_W'(frame_pkg::LQI_CYCLES - 1);
  wire cca_end = cca_run && cca_cnt == frame_pkg::WIN_W'(frame_pkg::CCA_CYCLES - 1);

  // Window counters start on the last preamble byte or the host request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lqi_run <= 1'b0;
      lqi_cnt <= '0;
      lqi_acc <= '0;
      lqi <= 8'h00;
    end else if (pre_end) begin
      lqi_run <= 1'b1; // RQ8
      lqi_cnt <= '0;
      lqi_acc <= '0;
    end else if (lqi_run) begin
      lqi_acc <= lqi_sum;
      lqi_cnt <= lqi_cnt + 12'h001;
      if (lqi_end) begin
        lqi_run <= 1'b0;
        lqi <= lqi_sum[frame_pkg::LQI_ACC_W-1 -: frame_pkg::LEVEL_W]; // RQ8
      end
    end
  end

  // A new request restarts a running assessment
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cca_run <= 1'b0;
      cca_cnt <= '0;
      cca_acc <= '0;
      cca_busy <= 1'b0;
    end else if (cmd_cca) begin
      cca_run <= 1'b1;
      cca_cnt <= '0;
      cca_acc <= '0;
    end else if (cca_run) begin
      cca_acc <= cca_sum;
      cca_cnt <= cca_cnt + 12'h001;
      if (cca_end) begin
        cca_run <= 1'b0;
        cca_busy <= cca_sum[frame_pkg::CCA_ACC_W-1 -: frame_pkg::LEVEL_W] > CCA_LEVEL; // RQ11
      end
    end
  end

  // ---------------------------------------------------------------------
  // Event flags and interrupt
  // ---------------------------------------------------------------------
  logic [frame_pkg::FLAG_N-1:0] flag_set;

  // Per-word events only in stream mode; a set beats a same-cycle clear
  always_comb begin
    flag_set = '0;
    flag_set[frame_pkg::F_RX_DONE] = rx_fin; // RQ9
    flag_set[frame_pkg::F_TX_DONE] = tx_fin; // RQ13
    flag_set[frame_pkg::F_RX_WORD] = stream && rx_in_pay; // RQ10
    flag_set[frame_pkg::F_TX_WORD] = stream && pay_take;
    flag_set[frame_pkg::F_CCA_DONE] = cca_end;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flags <= '0;
    end else begin
      flags <= (cmd_stat ? '0 : flags) | flag_set;
    end
  end

  assign irq_o = |flags; // RQ1

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  AST_TX_SFD_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ4
    tx_st == frame_pkg::TX_LEN |-> tx_byte_o == frame_pkg::SFD_BYTE)
    else $error("delimiter not on output before length byte");

  AST_TX_LEN_BYTE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ4
    tx_st == frame_pkg::TX_PAY && tx_cnt == '0 |-> tx_byte_o == len_byte)
    else $error("length byte is not payload plus check");

  AST_TX_FCS_LO: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ5
    tx_st == frame_pkg::TX_FCS && tx_cnt == '0 && out_free
    |=> tx_valid_o && tx_byte_o == $past(tx_crc[7:0]))
    else $error("first check byte wrong");

  AST_TX_DONE_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ13
    tx_fin |=> flags[frame_pkg::F_TX_DONE] && irq_o && tx_st == frame_pkg::TX_IDLE)
    else $error("no interrupt after frame sent");

  AST_RX_LEN_LIMIT: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ3
    rx_st == frame_pkg::RX_PAY |-> rx_len <= AW'(RX_DEPTH) && rx_len >= AW'(frame_pkg::FCS_N))
    else $error("payload length out of range");

  AST_RX_CRC: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ7
    rx_fin |=> crc_ok == ($past(rx_crc_next) == 16'h0000) && flags[frame_pkg::F_RX_DONE])
    else $error("check result does not match residue");

  AST_RX_ONE_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ9
    !stream && rx_in_pay && !rx_fin |=>
    flags[frame_pkg::F_RX_DONE] == $past(flags[frame_pkg::F_RX_DONE] && !cmd_stat) &&
    flags[frame_pkg::F_RX_WORD] == $past(flags[frame_pkg::F_RX_WORD] && !cmd_stat))
    else $error("packet mode raised a mid-packet event");

  AST_RX_WORD_IRQ: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ10
    stream && rx_in_pay |=> flags[frame_pkg::F_RX_WORD] && irq_o)
    else $error("stream word did not interrupt");

  AST_LQI_WINDOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ8
    $fell(lqi_run) && !$past(pre_end) |-> $past(lqi_cnt) == 12'(frame_pkg::LQI_CYCLES - 1))
    else $error("quality window length wrong");

  AST_CCA_WINDOW: assert property (@(posedge clk_i) disable iff (!resetn_i) // RQ11
    $fell(cca_run) && !$past(cmd_cca) |-> flags[frame_pkg::F_CCA_DONE] &&
    $past(cca_cnt) == 12'(frame_pkg::CCA_CYCLES - 1))
    else $error("assessment window length wrong");

endmodule

// file: verilog/frame_pkg.sv
// Purpose: Shared constants and state types for the low-rate PHY frame path
// Assumes: 20 MHz core clock, byte-wide modem data
// Notes: Times are kept in ns; cycle counts are derived from them

package frame_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int LQI_TIME_NS = 64000;
  localparam int CCA_TIME_NS = 128000;
  localparam int LQI_CYCLES = (LQI_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CCA_CYCLES = (CCA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_W = 12;
  localparam int LQI_ACC_W = 19;
  localparam int CCA_ACC_W = 20;
  localparam int LEVEL_W = 8;
  localparam logic [7:0] CCA_LEVEL = 8'h40;

  // ---------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------
  localparam int MAX_PAYLOAD = 125;
  localparam int FCS_N = 2;
  localparam int PRE_N = 4;
  localparam int IDX_W = 7;
  localparam logic [7:0] PRE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'ha7;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ---------------------------------------------------------------------
  // Host command word
  // ---------------------------------------------------------------------
  localparam int SPI_W = 16;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int CFG_MODE_BIT = 4;
  localparam int CHAN_W = 4;
  localparam int RD_LAST_BIT = 7;
  localparam logic [3:0] OP_CFG = 4'h1;
  localparam logic [3:0] OP_TX_WR = 4'h2;
  localparam logic [3:0] OP_TX_LEN = 4'h3;
  localparam logic [3:0] OP_TX_GO = 4'h4;
  localparam logic [3:0] OP_RX_GO = 4'h5;
  localparam logic [3:0] OP_RX_RD = 4'h6;
  localparam logic [3:0] OP_STAT = 4'h7;
  localparam logic [3:0] OP_CCA = 4'h8;

  // ---------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------
  localparam int FLAG_N = 5;
  localparam int F_RX_DONE = 0;
  localparam int F_TX_DONE = 1;
  localparam int F_RX_WORD = 2;
  localparam int F_TX_WORD = 3;
  localparam int F_CCA_DONE = 4;

  typedef enum logic [6:0] {
    TX_IDLE = 7'h01, TX_PRE = 7'h02, TX_SFD = 7'h04, TX_LEN = 7'h08,
    TX_PAY = 7'h10, TX_FCS = 7'h20, TX_DONE = 7'h40
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_OFF = 5'h01, RX_HUNT = 5'h02, RX_SFD = 5'h04, RX_LEN = 5'h08, RX_PAY = 5'h10
  } rx_state_t;

endpackage

// file: verilog/crc16_step.sv
// Purpose: One byte step of the reflected 16-bit frame check
// Assumes: Bits enter least significant first
// Notes: Purely combinational; the caller holds the running value

`timescale 1ns/10ps

module crc16_step #(
  parameter logic [15:0] POLY = frame_pkg::CRC_POLY_REV
) (
  // Running value and new byte
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [15:0] crc_o
);

  // Eight shifts, LSB first, so a good frame leaves a zero residue
  always_comb begin
    crc_o = crc_i;
    for (int b = 0; b < 8; b++) begin
      if (crc_o[0] ^ data_i[b]) begin
        crc_o = (crc_o >> 1) ^ POLY;
      end else begin
        crc_o = crc_o >> 1;
      end
    end
  end

endmodule

// file: verilog/spi_word_port.sv
// Purpose: Four-wire serial slave moving 16-bit words
// Assumes: Serial pins are synchronous to clk_i, clock idles low, MSB first
// Notes: Reply for a word is loaded when that word ends and shifts out next

`timescale 1ns/10ps

module spi_word_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Word side
  input wire logic [15:0] reply_i,
  output logic [15:0] word_o,
  output logic done_o
);

  logic sclk_q;
  logic [3:0] bit_cnt;
  logic [14:0] rx_sh;
  logic [15:0] tx_sh;

  // Edge detect on the sampled serial clock
  wire sel = !csn_i;
  wire rise = sel && sclk_i && !sclk_q;
  wire fall = sel && !sclk_i && sclk_q;

  // Word completes on the 16th rising edge; data taken straight from the pin
  assign done_o = rise && (bit_cnt == 4'hf);
  assign word_o = {rx_sh, mosi_i};
  assign miso_o = tx_sh[15];

  // Shift logic; no shift after the last bit so the fresh reply survives
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      bit_cnt <= 4'h0;
      rx_sh <= 15'h0000;
      tx_sh <= 16'h0000;
    end else begin
      sclk_q <= sclk_i;
      if (!sel) begin
        bit_cnt <= 4'h0;
      end else if (rise) begin
        bit_cnt <= bit_cnt + 4'h1;
        rx_sh <= {rx_sh[13:0], mosi_i};
      end
      if (done_o) begin
        tx_sh <= reply_i;
      end else if (fall && bit_cnt != 4'h0) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
    end
  end

endmodule

// file: tb/host_spi_model.sv
// Purpose: Host model that moves 16-bit words over the serial port
// Assumes: Mode 0, MSB first, pins change on falling core clock edges
// Notes: The reply to one word arrives while the next word shifts

`timescale 1ns/10ps

module host_spi_model (
  // Core clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic csn_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // Idle pins; clock idles low
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Slow serial levels, since the port samples them with the core clock
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge clk_i);
    csn_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = w[i];
      repeat (3) @(negedge clk_i);
      r[i] = miso_i;
      sclk_o = 1'b1;
      repeat (2) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    csn_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows no stale bit
  endtask
endmodule

// file: tb/lowrate_phy_frame_path_tb.sv
// Purpose: Self-checking bench for the frame path
// Assumes: Host model on the serial port, random modem stalls
// Notes: Transmit bytes are checked against a queue of expected bytes

`timescale 1ns/10ps

module lowrate_phy_frame_path_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sclk, csn, mosi, miso, irq, tx_valid;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] energy = 8'h80;
  logic [3:0] channel;
  logic [15:0] r;
  logic [15:0] c;
  logic [31:0] seed = 32'h0000_61be;
  logic [7:0] pay [$];
  logic [7:0] fr [$];
  logic [7:0] expq [$];
  int miscompares = 0;
  int checks = 0;

  always #25 clk_i = ~clk_i;

  host_spi_model host (.clk_i(clk_i), .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi), .miso_i(miso));
  lowrate_phy_frame_path dut (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
    .spi_csn_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso), .irq_o(irq), .tx_byte_o(tx_byte),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .energy_i(energy), .channel_o(channel));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reflected check, bit-serial so it shares nothing with the design
  function automatic logic [15:0] crc_of(input logic [7:0] q [$]);
    logic [15:0] v;
    v = 16'h0000;
    foreach (q[i]) for (int b = 0; b < 8; b++) v = (v[0] ^ q[i][b]) ? (v >> 1) ^ 16'h8408 : v >> 1;
    return v;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic stat();
    host.xfer({frame_pkg::OP_STAT, 12'h000}, r);
    host.xfer(16'h0000, r);
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 9000 && irq !== 1'b1; k++) @(negedge clk_i);
    check({15'h0000, irq}, 16'h0001);
  endtask

  // Modem stalls at random; every taken byte is matched against the oldest note
  always @(negedge clk_i) tx_ready <= 1'(rnd());
  always @(posedge clk_i) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      check({8'h00, tx_byte}, {8'h00, expq.size() > 0 ? expq.pop_front() : 8'hxx});
    end
  end

  // Packet mode loads first, then sends; stream mode feeds bytes after the request
  task automatic send_pkt(input int n, input logic strm);
    pay.delete();
    for (int i = 0; i < n; i++) pay.push_back(8'(rnd()));
    c = crc_of(pay);
    expq = {8'h00, 8'h00, 8'h00, 8'h00, frame_pkg::SFD_BYTE, 8'(n + 2), pay, c[7:0], c[15:8]};
    host.xfer({frame_pkg::OP_TX_LEN, 12'(n)}, r);
    if (strm) host.xfer({frame_pkg::OP_TX_GO, 12'h000}, r);
    foreach (pay[i]) host.xfer({frame_pkg::OP_TX_WR, 4'h0, pay[i]}, r);
    if (!strm) host.xfer({frame_pkg::OP_TX_GO, 12'h000}, r);
    if (strm) repeat (200) @(negedge clk_i); // Word events keep irq up; let the frame end
    wait_irq();
    stat();
    check(16'(expq.size()), 16'h0000);
    check(r, {2'b00, strm, 3'b010, 10'h000});
    check({15'h0000, irq}, 16'h0000);
  endtask

  // Back-to-back frame; irq checked after the second payload byte, set only when streaming
  task automatic recv(input int n, input logic bad, input logic strm);
    pay.delete();
    for (int i = 0; i < n; i++) pay.push_back(8'(rnd()));
    c = crc_of(pay) ^ {7'h00, bad, 8'h00};
    fr = {8'h00, 8'h00, 8'h00, 8'h00, frame_pkg::SFD_BYTE, 8'(n + 2), pay, c[7:0], c[15:8]};
    host.xfer({frame_pkg::OP_RX_GO, 12'h000}, r);
    foreach (fr[i]) begin
      @(negedge clk_i);
      if (i == 8) check({15'h0000, irq}, {15'h0000, strm});
      rx_valid = 1'b1;
      rx_byte = fr[i];
    end
    @(negedge clk_i);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    repeat (1300) @(negedge clk_i);
    stat();
    check(r, {3'b000, strm, 3'b010, ~bad, 8'h50});
    host.xfer({frame_pkg::OP_RX_RD, 12'h001}, r);
    host.xfer({frame_pkg::OP_RX_RD, 12'h080}, r);
    check(r, {8'h00, pay[1]});
    host.xfer(16'h0000, r);
    check(r, {8'h00, c[15:8]});
  endtask

  // Main sequence
  initial begin
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    check({10'h000, irq, tx_valid, channel}, 16'h0000);
    for (int ch = 15; ch >= 0; ch--) begin
      host.xfer({frame_pkg::OP_CFG, 7'h00, 1'b0, 4'(ch)}, r);
      repeat (2) @(negedge clk_i);
      check({12'h000, channel}, 16'(ch));
    end
    host.xfer({frame_pkg::OP_CFG, 7'h00, 1'b1, 4'h0}, r);
    send_pkt(5, 1'b1);
    host.xfer({frame_pkg::OP_CFG, 7'h00, 1'b0, 4'h0}, r);
    send_pkt(3, 1'b0);
    send_pkt(125, 1'b0);
    recv(3, 1'b0, 1'b0);
    recv(4, 1'b1, 1'b0);
    host.xfer({frame_pkg::OP_CFG, 7'h00, 1'b1, 4'h0}, r);
    recv(3, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      energy = (i == 0) ? 8'h80 : 8'h20;
      host.xfer({frame_pkg::OP_CCA, 12'h000}, r);
      wait_irq();
      stat();
      check({10'h000, r[14:9]}, {10'h000, 5'b10000, i == 0});
    end
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
endmodule
